// file: sct_asserts.sv
/* checker for sct_timer: apb answers, lockout, control shadow, pins.
   assumes a bind onto sct_timer; sees only its ports. */
`timescale 1ns/1ps
`include "sct_regs.vh"
module sct_asserts (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SCT_AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins and interrupt
    input wire [23:0] cc_pin_oe,
    input wire irq
);
////////////////////////////////////////
wire acc = psel && penable;
wire in_lock = paddr >= `SCT_LOCK_LO && paddr <= `SCT_LOCK_HI;
wire is_ctl = paddr[11:6] == 6'h3A && paddr[5:3] < 3'h6 && paddr[2:0] == 3'h0;
// bit 7 exists only on the four-general channels
wire [7:0] ctl_mask = (paddr[5:3] == 3'h0 || paddr[5:3] == 3'h3) ? 8'hFF : 8'h7F;
reg lock_q;
reg [7:0] ctl_q [0:5];
integer i;
always @(posedge clk_sys) begin
    if (srst) begin
        lock_q <= 1'h0;
        for (i = 0; i < 6; i = i + 1) begin
            ctl_q[i] <= 8'h00;
        end
    end else if (acc && pwrite) begin
        if (paddr == `SCT_SYS2_ADDR) begin
            lock_q <= pwdata[0];
        end
        if (is_ctl && !lock_q) begin
            ctl_q[paddr[5:3]] <= pwdata[7:0] & ctl_mask;
        end
    end
end
default clocking @(posedge clk_sys); endclocking
default disable iff (srst);
pready_up_a: assert property (pready) else $error("pready low");
lock_block_a: assert property (acc && lock_q && in_lock |-> pslverr && prdata == 32'h0)
    else $error("locked access answered");
ctl_open_a: assert property (acc && !lock_q && is_ctl |-> !pslverr)
    else $error("open control access refused");
ctl_value_a: assert property (acc && !pwrite && !lock_q && is_ctl |-> prdata[7:0] == ctl_q[paddr[5:3]])
    else $error("control read mismatch");
lock_flag_a: assert property (acc && !pwrite && paddr == `SCT_SYS2_ADDR |-> prdata[0] == lock_q)
    else $error("flash select readback wrong");
unmapped_err_a: assert property (acc && paddr == 12'hFFC |-> pslverr && prdata == 32'h0)
    else $error("unmapped access answered");
narrow_pins_a: assert property ((cc_pin_oe & 24'hCC0CC0) == 24'h0)
    else $error("c/d pin driven on two-general channel");
reset_quiet_a: assert property ($past(srst) |-> !irq && cc_pin_oe == 24'h0)
    else $error("outputs active after reset");
lock_seen_c: cover property (acc && lock_q && in_lock);
irq_seen_c: cover property ($rose(irq));
ctl_write_c: cover property (acc && pwrite && is_ctl && !lock_q);
endmodule

// file: sct_pins_model.sv
/* far side: external clock sources and capture/compare lines.
   assumes the bench calls pulse and quad; pins resolve from oe. */
`timescale 1ns/1ps
module sct_pins_model (
    // clock
    input wire clk_sys,
    // from the timer
    input wire [23:0] cc_pin_out,
    input wire [23:0] cc_pin_oe,
    // into the timer
    output wire [3:0] ext_clk,
    output wire [23:0] cc_pin_in
);
////////////////////////////////////////
// bits 3:0 ext clocks a..d, 27:4 capture lines
reg [27:0] p_q = 28'h0;
assign ext_clk = p_q[3:0];
assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & p_q[27:4]);
// 8 clocks per level clears the 3-stage filter with margin
task pulse(input int n);
    @(posedge clk_sys);
    p_q[n] <= 1'h1;
    repeat (8) @(posedge clk_sys);
    p_q[n] <= 1'h0;
    repeat (8) @(posedge clk_sys);
endtask
// forward steps {b,a}: 01 11 10 00, pair p on ext bits 2p, 2p+1
task quad(input int p);
    for (int s = 0; s < 4; s++) begin
        @(posedge clk_sys);
        p_q[2*p +: 2] <= 8'h2D >> (2 * s);
        repeat (8) @(posedge clk_sys);
    end
endtask
endmodule

// file: sct_regs.vh
/*
 * register map, field positions, reset values and timing counts of the
 * six-channel timer unit.
 * assumes a 12-bit apb byte address and 32-bit data, one word per register.
 */
`ifndef SCT_REGS_VH
`define SCT_REGS_VH

`define SCT_AW 12
// lockout range of the control block
`define SCT_LOCK_LO 12'hE80
`define SCT_LOCK_HI 12'hEB1
// control block: channel n at LOCK_LO + n * CTL_STRIDE
`define SCT_CTL_STRIDE 12'h008
`define SCT_CTL_OFS 12'h000
`define SCT_IO_OFS 12'h004
// data block: channel n at DATA_BASE + n * DATA_STRIDE
`define SCT_DATA_BASE 12'hF00
`define SCT_DATA_STRIDE 12'h020
`define SCT_CNT_OFS 12'h000
`define SCT_GR_OFS 12'h004
`define SCT_IEN_OFS 12'h014
`define SCT_STAT_OFS 12'h018
// common registers
`define SCT_START_ADDR 12'hEC0
`define SCT_SYNC_ADDR 12'hEC4
`define SCT_SYS2_ADDR 12'hEC8
// counter control fields
`define SCT_CLR_HI 7
`define SCT_CLR_LO 5
`define SCT_EDGE_HI 4
`define SCT_EDGE_LO 3
`define SCT_CSEL_HI 2
`define SCT_CSEL_LO 0
`define SCT_CTL_RST 8'h00
// mode bits
`define SCT_MODE_PHASE 0
`define SCT_MODE_PWM 1
// status / enable bits: 0..3 general a..d, 4 overflow, 5 underflow
`define SCT_ST_OVF 4
`define SCT_ST_UNF 5
// io codes per general register
`define SCT_IO_OFF 2'h0
`define SCT_IO_CMP 2'h1
`define SCT_IO_CAPR 2'h2
`define SCT_IO_CAPB 2'h3
// input filter depth in clocks before a pin change is seen
`define SCT_SYNC_STAGES 3

`endif

// file: sct_timer.v
/*
 * six-channel 16-bit timer: apb register file, external clock and
 * quadrature inputs, capture/compare/pwm pins, clear sources, interrupt.
 * assumes an apb master on clk_sys and asynchronous pins that are
 * filtered here; the pad ring resolves each pin from out and oe.
 */
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sct_regs.vh"

module sct_timer (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SCT_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // external clock pins
    input wire ext_clock_in_a,
    input wire ext_clock_in_b,
    input wire ext_clock_in_c,
    input wire ext_clock_in_d,
    // capture/compare pins, channel n at bits 4n..4n+3 (a..d)
    input wire [23:0] cc_pin_in,
    output wire [23:0] cc_pin_out,
    output wire [23:0] cc_pin_oe,
    // interrupt
    output wire irq
);

    ////////////////////////////////////////////////////////////////////
    // apb decode

    wire acc = psel & penable;
    wire in_lock = (paddr >= `SCT_LOCK_LO) && (paddr <= `SCT_LOCK_HI);
    reg flash_iface_select_q;
    wire blocked = flash_iface_select_q & in_lock;
    wire wr = acc & pwrite & ~blocked;
    wire rd = acc & ~pwrite & ~blocked;
    wire [5:0] ch_hit;
    wire [191:0] ch_rdata;
    wire [5:0] ch_irq;
    wire [5:0] own_clr;
    reg [5:0] common_count_start_q;
    reg [5:0] common_sync_select_q;
    wire com_hit = (paddr == `SCT_START_ADDR) || (paddr == `SCT_SYNC_ADDR) || (paddr == `SCT_SYS2_ADDR);

    // zero wait states keep the access phase one cycle long
    assign pready = 1'b1;
    assign pslverr = acc & (blocked | ~(com_hit | (|ch_hit)));
    assign irq = |ch_irq;

    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h00000000;
        if (!blocked) begin
            if (paddr == `SCT_START_ADDR)
                rdata_d = {26'h0000000, common_count_start_q};
            else if (paddr == `SCT_SYNC_ADDR)
                rdata_d = {26'h0000000, common_sync_select_q};
            else if (paddr == `SCT_SYS2_ADDR)
                rdata_d = {31'h00000000, flash_iface_select_q};
            else
                rdata_d = ch_rdata[31:0] | ch_rdata[63:32] | ch_rdata[95:64] |
                          ch_rdata[127:96] | ch_rdata[159:128] | ch_rdata[191:160];
        end
    end

    // read data is taken in the setup phase: the port comes from a flop
    // and the access phase still needs no wait state
    always @(posedge clk_sys) begin
        if (srst)
            prdata <= 32'h00000000;
        else if (psel & ~penable)
            prdata <= rdata_d;
    end

    // common registers shared by every channel
    always @(posedge clk_sys) begin
        if (srst) begin
            common_count_start_q <= 6'h00;
            common_sync_select_q <= 6'h00;
            flash_iface_select_q <= 1'b0;
        end else if (wr) begin
            if (paddr == `SCT_START_ADDR)
                common_count_start_q <= pwdata[5:0];
            if (paddr == `SCT_SYNC_ADDR)
                common_sync_select_q <= pwdata[5:0];
            // the select bit itself sits outside the locked range
            if (paddr == `SCT_SYS2_ADDR)
                flash_iface_select_q <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin filter: a change counts once stages two and three agree

    wire [27:0] pin_raw = {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a, cc_pin_in};
    reg [27:0] s1_q, s2_q, s3_q, flt_q, fltp_q;
    wire [27:0] flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
    wire [27:0] rise = flt_q & ~fltp_q;
    wire [27:0] fall = ~flt_q & fltp_q;

    always @(posedge clk_sys) begin
        if (srst) begin
            s1_q <= 28'h0000000;
            s2_q <= 28'h0000000;
            s3_q <= 28'h0000000;
            flt_q <= 28'h0000000;
            fltp_q <= 28'h0000000;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
            fltp_q <= flt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared prescaler: /1 /4 /16 /64

    reg [5:0] pre_q;
    always @(posedge clk_sys) begin
        if (srst)
            pre_q <= 6'h00;
        else
            pre_q <= pre_q + 6'h01;
    end
    wire [3:0] pre_tick = {pre_q == 6'h3F, pre_q[3:0] == 4'hF, pre_q[1:0] == 2'h3, 1'b1};

    ////////////////////////////////////////////////////////////////////
    // channels

    genvar n, k;
    generate
        for (n = 0; n < 6; n = n + 1) begin : g_ch
            // four generals and split io control only on channels 0 and 3
            localparam NGR = (n == 0 || n == 3) ? 4 : 2;
            localparam PH = (n == 1 || n == 5) ? 1 : ((n == 2 || n == 4) ? 2 : 0);
            localparam integer CB = `SCT_LOCK_LO + n * `SCT_CTL_STRIDE;
            localparam integer DB = `SCT_DATA_BASE + n * `SCT_DATA_STRIDE;
            localparam [11:0] CBASE = CB[11:0];
            localparam [11:0] DBASE = DB[11:0];

            reg [7:0] ctl_q;
            reg [1:0] mode_q;
            reg [7:0] ioh_q, iol_q;
            reg [15:0] cnt_q;
            reg [63:0] gr_q;
            reg [5:0] ien_q, st_q;
            reg [3:0] out_q;
            wire [3:0] ev;
            wire [3:0] gr_cap;
            wire [15:0] io_all = {iol_q, ioh_q};

            wire a_ctl = paddr == CBASE + `SCT_CTL_OFS;
            wire a_io = paddr == CBASE + `SCT_IO_OFS;
            wire a_cnt = paddr == DBASE + `SCT_CNT_OFS;
            wire a_ien = paddr == DBASE + `SCT_IEN_OFS;
            wire a_st = paddr == DBASE + `SCT_STAT_OFS;
            wire [3:0] a_gr;
            wire [2:0] clr_src = ctl_q[`SCT_CLR_HI:`SCT_CLR_LO];
            wire [1:0] edge_sel = ctl_q[`SCT_EDGE_HI:`SCT_EDGE_LO];
            wire [2:0] csel = ctl_q[`SCT_CSEL_HI:`SCT_CSEL_LO];
            wire run = common_count_start_q[n];

            // clock source: external edges follow the edge field
            wire [1:0] ext_i = csel[1:0];
            wire ext_r = rise[24 + ext_i];
            wire ext_f = fall[24 + ext_i];
            wire ext_tick = edge_sel[1] ? (ext_r | ext_f) : (edge_sel[0] ? ext_f : ext_r);
            wire norm_tick = csel[2] ? ext_tick : pre_tick[csel[1:0]];

            // quadrature on a/b for ch1/5 and on c/d for ch2/4
            wire ph_on = (PH != 0) & mode_q[`SCT_MODE_PHASE];
            wire [4:0] pa = (PH == 2) ? 5'd26 : 5'd24;
            wire qa = flt_q[pa];
            wire qb = flt_q[pa + 5'd1];
            wire qap = fltp_q[pa];
            wire qbp = fltp_q[pa + 5'd1];
            wire q_step = (qa ^ qap) | (qb ^ qbp);
            wire q_up = qa ^ qbp;

            wire step = run & (ph_on ? q_step : norm_tick);
            wire up = ph_on ? q_up : 1'b1;
            wire ovf = step & up & (cnt_q == 16'hFFFF);
            wire unf = step & ~up & (cnt_q == 16'h0000);

            // clear source; bit 7 is reserved on two-general channels
            // only own sources feed the sync net, so channels never loop through each other
            wire sync_clr = |(own_clr & common_sync_select_q & ~(6'h01 << n));
            reg src_clr;
            always @* begin
                case (clr_src)
                    3'h1: src_clr = ev[0];
                    3'h2: src_clr = ev[1];
                    3'h5: src_clr = ev[2];
                    3'h6: src_clr = ev[3];
                    default: src_clr = 1'b0;
                endcase
            end
            wire sync_code = (clr_src[1:0] == 2'h3);
            wire clr = src_clr | (sync_code & common_sync_select_q[n] & sync_clr);
            assign own_clr[n] = src_clr;

            for (k = 0; k < 4; k = k + 1) begin : g_gr
                // a and b sit in the low io byte (ioh_q), c and d in the high one (iol_q)
                wire [1:0] io = io_all[2 * k + ((k >= 2) ? 4 : 0) +: 2];
                wire cap = (io == `SCT_IO_CAPB) ? (rise[4 * n + k] | fall[4 * n + k]) : rise[4 * n + k];
                assign gr_cap[k] = (k < NGR) & io[1] & cap;
                wire match = (k < NGR) & ~io[1] & step & (cnt_q == gr_q[16 * k +: 16]);
                assign ev[k] = gr_cap[k] | match;
                assign a_gr[k] = (k < NGR) && (paddr == DBASE + `SCT_GR_OFS + 4 * k);
                // pwm on pin a: high while the count is below general a
                wire pwm_pin = (k == 0) & mode_q[`SCT_MODE_PWM];
                assign cc_pin_oe[4 * n + k] = (k < NGR) & (pwm_pin | (io == `SCT_IO_CMP));
                assign cc_pin_out[4 * n + k] = out_q[k];
                always @(posedge clk_sys) begin
                    if (srst)
                        out_q[k] <= 1'b0;
                    else if (pwm_pin)
                        out_q[k] <= cnt_q < gr_q[15:0];
                    else if (match)
                        out_q[k] <= ~out_q[k];
                end
                always @(posedge clk_sys) begin
                    if (srst)
                        gr_q[16 * k +: 16] <= 16'h0000;
                    else if (wr & a_gr[k])
                        gr_q[16 * k +: 16] <= pwdata[15:0];
                    else if (gr_cap[k])
                        gr_q[16 * k +: 16] <= cnt_q;
                end
            end

            always @(posedge clk_sys) begin
                if (srst) begin
                    ctl_q <= `SCT_CTL_RST;
                    mode_q <= 2'h0;
                    ioh_q <= 8'h00;
                    iol_q <= 8'h00;
                    ien_q <= 6'h00;
                    st_q <= 6'h00;
                    cnt_q <= 16'h0000;
                end else begin
                    if (wr & a_ctl) begin
                        // counting while rewritten is not supported
                        ctl_q <= (NGR == 4) ? pwdata[7:0] : {1'b0, pwdata[6:0]};
                        mode_q <= pwdata[9:8];
                    end
                    if (wr & a_io) begin
                        ioh_q <= pwdata[7:0];
                        if (NGR == 4)
                            iol_q <= pwdata[15:8];
                    end
                    if (wr & a_ien)
                        ien_q <= pwdata[5:0];
                    // set wins over read-clear; only the bits returned are cleared,
                    // so an event between setup and access survives
                    st_q <= (st_q & ~((rd & a_st) ? prdata[5:0] : 6'h00)) | {unf, ovf, ev};
                    if (wr & a_cnt)
                        cnt_q <= pwdata[15:0];
                    else if (clr)
                        cnt_q <= 16'h0000;
                    else if (step)
                        cnt_q <= up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
            end

            assign ch_irq[n] = |(st_q & ien_q);
            assign ch_hit[n] = a_ctl | a_io | a_cnt | a_ien | a_st | (|a_gr);
            assign ch_rdata[32 * n +: 32] =
                a_ctl ? {22'h000000, mode_q, ctl_q} :
                a_io ? {16'h0000, iol_q, ioh_q} :
                a_cnt ? {16'h0000, cnt_q} :
                a_ien ? {26'h0000000, ien_q} :
                a_st ? {26'h0000000, st_q} :
                a_gr[0] ? {16'h0000, gr_q[15:0]} :
                a_gr[1] ? {16'h0000, gr_q[31:16]} :
                a_gr[2] ? {16'h0000, gr_q[47:32]} :
                a_gr[3] ? {16'h0000, gr_q[63:48]} : 32'h00000000;
        end
    endgenerate

endmodule

// file: tb_six_channel_timer_pins_and_control.sv
/* testbench for sct_timer: register table, lockout, counting, irq.
   assumes sct_pins_model on the pins and sct_asserts bound below. */
`timescale 1ns/1ps
`include "sct_regs.vh"
module tb_six_channel_timer_pins_and_control;
logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, irq, re, t;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [23:0] cc_pin_in, cc_pin_out, cc_pin_oe;
wire [3:0] ext_clk;
int n_mismatch, num_checks, w;
typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} sct_row_t;
sct_row_t rows [0:8] = '{
    '{12'hE80, 32'hE0, 32'hE0, 1'h0}, '{12'hE88, 32'hFF, 32'h7F, 1'h0},
    '{12'hE98, 32'hA5, 32'hA5, 1'h0}, '{12'hEA8, 32'h3FF, 32'h37F, 1'h0},
    '{12'hEC4, 32'h3F, 32'h3F, 1'h0}, '{12'hE84, 32'hFFFF, 32'hFFFF, 1'h0},
    '{12'hE8C, 32'hFFFF, 32'hFF, 1'h0}, '{12'hF10, 32'hBEEF, 32'hBEEF, 1'h0},
    '{12'hFFC, 32'h1234, 32'h0, 1'h1}};
sct_timer dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in_a(ext_clk[0]), .ext_clock_in_b(ext_clk[1]), .ext_clock_in_c(ext_clk[2]),
    .ext_clock_in_d(ext_clk[3]), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .irq(irq));
sct_pins_model pins (.clk_sys(clk_sys), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
    .ext_clk(ext_clk), .cc_pin_in(cc_pin_in));
initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
end
////////////////////////////////////////
task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
endtask
task chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'h0, a, 32'h0);
    num_checks++;
    if (rd !== x || re !== xe) begin
        n_mismatch++;
        $display("CHECK FAILED reg %h expected %h/%h seen %h/%h", a, x, xe, rd, re);
    end
endtask
task flag(input string nm, input logic g, input logic x);
    num_checks++;
    if (g !== x) begin
        n_mismatch++;
        $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
endtask
task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
// the run needs about 730 clocks
initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    final_report;
end
initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
    repeat (20) @(posedge clk_sys);
    srst <= 1'h0;
    foreach (rows[i]) begin
        chk(rows[i].a, 32'h0, rows[i].e);
        wr(rows[i].a, rows[i].w);
        chk(rows[i].a, rows[i].r, rows[i].e);
    end
    $display("register table done");
    wr(`SCT_SYS2_ADDR, 32'h1);
    wr(12'hE80, 32'h40);
    chk(12'hE80, 32'h0, 1'h1);
    chk(12'hEB0, 32'h0, 1'h1);
    chk(`SCT_SYNC_ADDR, 32'h3F, 1'h0);
    wr(`SCT_SYS2_ADDR, 32'h0);
    chk(12'hE80, 32'hE0, 1'h0);
    wr(`SCT_SYNC_ADDR, 32'h0);
    $display("lockout done");
    // control is only rewritten with the counter stopped
    for (int k = 0; k < 4; k++) begin
        wr(`SCT_START_ADDR, 32'h0);
        wr(12'hF00, 32'h0);
        wr(12'hE80, 32'(9 * k + 4)); // source ext pin k, edge code k
        wr(`SCT_START_ADDR, 32'h1);
        repeat (2) pins.pulse(k);
        wr(`SCT_START_ADDR, 32'h0);
        chk(12'hF00, (k < 2) ? 32'h2 : 32'h4, 1'h0);
    end
    for (int p = 0; p < 2; p++) begin
        wr(12'hE88 + 12'(8 * p), 32'h100);
        wr(12'hF20 + 12'(32 * p), 32'h0);
        wr(`SCT_START_ADDR, 32'(2 << p));
        pins.quad(p);
        wr(`SCT_START_ADDR, 32'h0);
        chk(12'hF20 + 12'(32 * p), 32'h4, 1'h0);
    end
    $display("counting done");
    wr(12'hE84, 32'h2);
    wr(12'hE80, 32'h25);
    wr(12'hF00, 32'h0);
    wr(12'hF14, 32'h1);
    // keep general b and c out of reach so only the capture flags
    wr(12'hF08, 32'h1000);
    wr(12'hF0C, 32'h1000);
    wr(`SCT_START_ADDR, 32'h1);
    repeat (3) pins.pulse(1);
    pins.pulse(4);
    flag("irq raised", irq, 1'h1);
    chk(12'hF04, 32'h3, 1'h0);
    chk(12'hF00, 32'h0, 1'h0);
    chk(12'hF18, 32'h1, 1'h0);
    @(negedge clk_sys);
    flag("irq cleared", irq, 1'h0);
    wr(12'hF14, 32'h0);
    pins.pulse(4);
    flag("irq masked", irq, 1'h0);
    chk(12'hF18, 32'h1, 1'h0);
    wr(`SCT_START_ADDR, 32'h0);
    wr(12'hE98, 32'h0);
    wr(12'hF64, 32'h10);
    wr(12'hE9C, 32'h1);
    @(negedge clk_sys);
    flag("oe ch3 a", cc_pin_oe[12], 1'h1);
    t = cc_pin_out[12];
    wr(`SCT_START_ADDR, 32'h8);
    for (w = 0; w < 200 && cc_pin_out[12] === t; w++) @(posedge clk_sys);
    flag("compare toggle", cc_pin_out[12] !== t, 1'h1);
    $display("capture compare done");
    wr(`SCT_START_ADDR, 32'h0);
    wr(12'hF60, 32'h0);
    wr(12'hF80, 32'h0);
    wr(12'hE98, 32'h20);
    wr(12'hEA0, 32'h60);
    wr(`SCT_SYNC_ADDR, 32'h18);
    wr(`SCT_START_ADDR, 32'h18);
    repeat (100) @(posedge clk_sys);
    wr(`SCT_START_ADDR, 32'h0);
    apb(1'h0, 12'hF60, 32'h0);
    w = rd;
    apb(1'h0, 12'hF80, 32'h0);
    flag("sync clear", rd === w && w <= 16, 1'h1);
    $display("sync clear done");
    srst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'h0;
    chk(12'hE80, 32'h0, 1'h0);
    flag("oe after reset", |cc_pin_oe, 1'h0);
    $display("reset done");
    final_report;
end
endmodule
bind sct_timer sct_asserts u_asserts (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc_pin_oe(cc_pin_oe), .irq(irq));
